// *** rtl/glan_regs.svh ***
// Bit positions, encodings and timing counts of the negotiation word
`ifndef GLAN_REGS_SVH
`define GLAN_REGS_SVH
`define GLAN_BIT_FULL      5
`define GLAN_BIT_HALF      6
`define GLAN_BIT_PAUSE     7
`define GLAN_BIT_ASYM      8
`define GLAN_BIT_RF_LO     12
`define GLAN_BIT_RF_HI     13
`define GLAN_BIT_ACK       14
`define GLAN_BIT_MORE      15
`define GLAN_RSVD_MASK     16'h0E1F
`define GLAN_FAULT_NONE    2'h0
`define GLAN_MATCH_COUNT   3
`define GLAN_LINK_TIME_NS  10000000
`define GLAN_CLK_NS        20
`define GLAN_LINK_CYCLES   (`GLAN_LINK_TIME_NS / `GLAN_CLK_NS)
`endif

// *** rtl/glan_pkg.sv ***
// Types shared by the negotiation logic
package glan_pkg;
   typedef enum logic [2:0] {
      GLAN_DISABLED,
      GLAN_RESTART,
      GLAN_ABILITY,
      GLAN_ACK_DETECT,
      GLAN_COMPLETE_ACK,
      GLAN_NEXT_PAGE_WAIT,
      GLAN_LINK_OK
   } glan_state_t;
   typedef enum logic [1:0] {
      GLAN_PAUSE_NONE,
      GLAN_PAUSE_ASYM_TX,
      GLAN_PAUSE_SYM,
      GLAN_PAUSE_ASYM_RX
   } glan_pause_t;
endpackage

// *** rtl/glan_match.sv ***
// Receive word checker: three consecutive matching words, Ack ignored
`timescale 1ns/1ps
`include "glan_regs.svh"
module glan_match #(
   parameter int COUNT = `GLAN_MATCH_COUNT
) (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        clear_i,
   input  wire logic        rx_valid_i,
   input  wire logic [15:0] rx_word_i,
   output logic             stable_o,
   output logic [15:0]      word_o
);
   localparam logic [15:0] ACK_MASK = 16'h4000;
   logic [15:0] last;
   logic [15:0] next_last;
   logic [2:0]  cnt;
   logic [2:0]  next_cnt;
   logic        next_stable;
   logic [15:0] next_word;

   // Compare each word with the previous one, Ack bit masked out
   always_comb begin
      next_last   = last;
      next_cnt    = cnt;
      next_stable = 1'b0;
      next_word   = word_o;
      if (clear_i) begin
         next_cnt = 3'h0;
      end else if (rx_valid_i) begin
         next_last = rx_word_i;
         if ((cnt != 3'h0) && ((rx_word_i & ~ACK_MASK) == (last & ~ACK_MASK))) begin
            if (cnt < 3'(COUNT)) begin
               next_cnt = cnt + 3'h1;
            end
         end else begin
            next_cnt = 3'h1;
         end
         if (next_cnt == 3'(COUNT)) begin
            next_stable = 1'b1;
            next_word   = rx_word_i;
         end
      end
   end

   // Registers only
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         last     <= 16'h0000;
         cnt      <= 3'h0;
         stable_o <= 1'b0;
         word_o   <= 16'h0000;
      end else begin
         last     <= next_last;
         cnt      <= next_cnt;
         stable_o <= next_stable;
         word_o   <= next_word;
      end
   end
endmodule

// *** rtl/glan_autoneg.sv ***
// Link auto-negotiation: page exchange, acknowledgment and mode resolution
// Functional notes
// - Word carries duplex, pause, fault, ack, more-pages
// - Reserved word bits always transmitted as zero
// - Send config sets at powerup, restart, error
// - Decode partner page, find highest common ability
// - Answer received page with Ack set
// - Enable mode after acks and next pages
// - More pages requested via more-pages bit
// - Management disables negotiation or forces mode
// - Runs to completion with no management; here any next-page exchange waits in GLAN_NEXT_PAGE_WAIT for next_page_load_i
// - No negotiation signalling on media-independent side
// - Control and status follow standard management layout
// - Ack after three matching words, Ack ignored
// - Send zero words first, then base page
// - Pause bits: none, asym, sym, both
// - Default fault code zero without fault detection
`timescale 1ns/1ps
`include "glan_regs.svh"
module glan_autoneg #(
   parameter int LINK_CYCLES = `GLAN_LINK_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   // Management controls: an_enable_i must be held high for negotiation to run standalone
   input  wire logic        an_enable_i,
   input  wire logic        an_restart_i,
   input  wire logic        force_full_duplex_i,
   input  wire logic        full_duplex_ability_i,
   input  wire logic        half_duplex_ability_i,
   input  wire logic        symmetric_pause_ability_i,
   input  wire logic        asymmetric_pause_direction_i,
   input  wire logic [1:0]  fault_code_i,
   input  wire logic        more_pages_request_i,
   input  wire logic [15:0] next_page_word_i,
   input  wire logic        next_page_load_i,
   // Link side
   input  wire logic        phy_error_i,
   input  wire logic        rx_config_valid_i,
   input  wire logic [15:0] rx_config_word_i,
   input  wire logic        rx_idle_i,
   output logic             tx_config_en_o,
   output logic [15:0]      tx_config_word_o,
   // Status
   output logic             an_complete_o,
   output logic             link_up_o,
   output logic             mode_full_duplex_o,
   output logic [1:0]       mode_pause_o,
   output logic             partner_fault_o,
   output logic             an_error_o,
   output logic [15:0]      partner_word_o,
   output logic             next_page_rx_o
);
   localparam int CW = $clog2(LINK_CYCLES + 1);

   glan_pkg::glan_state_t state;
   glan_pkg::glan_state_t next_state;
   logic [CW-1:0] timer;
   logic [CW-1:0] next_timer;
   logic          extra_phase;
   logic          next_extra_phase;
   logic [15:0]   extra_word;
   logic [15:0]   next_extra_word;
   logic          clr_match;
   logic          match_stable;
   logic [15:0]   match_word;
   logic          next_tx_en;
   logic [15:0]   next_tx_word;
   logic          next_complete;
   logic          next_link;
   logic          next_full;
   glan_pkg::glan_pause_t next_pause;
   logic          next_pfault;
   logic          next_err;
   logic [15:0]   next_pword;
   logic          next_nprx;
   logic [15:0]   base_page;
   logic          common_full;
   logic          common_half;
   logic          timer_done;

   glan_match u_match (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .clear_i    (clr_match),
      .rx_valid_i (rx_config_valid_i),
      .rx_word_i  (rx_config_word_i),
      .stable_o   (match_stable),
      .word_o     (match_word)
   );

   // Base page assembly; reserved bits stay zero by construction
   always_comb begin
      base_page = 16'h0000;
      base_page[`GLAN_BIT_FULL]  = full_duplex_ability_i;
      base_page[`GLAN_BIT_HALF]  = half_duplex_ability_i;
      base_page[`GLAN_BIT_PAUSE] = symmetric_pause_ability_i;
      base_page[`GLAN_BIT_ASYM]  = asymmetric_pause_direction_i;
      // Fault code is only what management supplies; no local detection here
      base_page[`GLAN_BIT_RF_HI:`GLAN_BIT_RF_LO] = fault_code_i;
      base_page[`GLAN_BIT_MORE]  = more_pages_request_i;
   end

   // Common ability of the two ends, full duplex preferred
   assign common_full = full_duplex_ability_i & match_word[`GLAN_BIT_FULL];
   assign common_half = half_duplex_ability_i & match_word[`GLAN_BIT_HALF];
   assign timer_done = (timer == CW'(LINK_CYCLES));

   // Negotiation sequencer
   always_comb begin
      next_state    = state;
      next_timer    = timer;
      next_extra_phase = extra_phase;
      next_extra_word  = extra_word;
      clr_match     = 1'b0;
      next_tx_en    = 1'b1;
      next_tx_word  = 16'h0000;
      next_complete = an_complete_o;
      next_link     = link_up_o;
      next_full     = mode_full_duplex_o;
      next_pause    = glan_pkg::glan_pause_t'(mode_pause_o);
      next_pfault   = partner_fault_o;
      next_err      = an_error_o;
      next_pword    = partner_word_o;
      next_nprx     = 1'b0;
      if (next_page_load_i) begin
         next_extra_word = next_page_word_i & ~`GLAN_RSVD_MASK;
      end
      if (!an_enable_i) begin
         // Negotiation off: forced mode, link carries data only
         next_state    = glan_pkg::GLAN_DISABLED;
         next_tx_en    = 1'b0;
         next_complete = 1'b0;
         next_link     = 1'b1;
         next_full     = force_full_duplex_i;
         next_pause    = glan_pkg::GLAN_PAUSE_NONE;
      end else if (an_restart_i || phy_error_i) begin
         // Restart from zero words on command or link error
         next_state    = glan_pkg::GLAN_RESTART;
         next_timer    = '0;
         next_complete = 1'b0;
         next_link     = 1'b0;
         next_extra_phase = 1'b0;
         clr_match     = 1'b1;
      end else begin
         case (state)
            glan_pkg::GLAN_DISABLED: begin
               next_state = glan_pkg::GLAN_RESTART;
               next_timer = '0;
               next_link  = 1'b0;
               clr_match  = 1'b1;
            end
            glan_pkg::GLAN_RESTART: begin
               next_tx_word = 16'h0000;
               next_timer   = timer + CW'(1);
               clr_match    = 1'b1;
               if (timer_done) begin
                  next_state = glan_pkg::GLAN_ABILITY;
                  next_timer = '0;
               end
            end
            glan_pkg::GLAN_ABILITY: begin
               next_tx_word = extra_phase ? extra_word : base_page;
               if (match_stable && (match_word != 16'h0000)) begin
                  next_state = glan_pkg::GLAN_ACK_DETECT;
               end
            end
            glan_pkg::GLAN_ACK_DETECT: begin
               next_tx_word = (extra_phase ? extra_word : base_page);
               next_tx_word[`GLAN_BIT_ACK] = 1'b1;
               if (rx_config_valid_i && rx_config_word_i[`GLAN_BIT_ACK] &&
                   ((rx_config_word_i & 16'hBFFF) == (match_word & 16'hBFFF))) begin
                  next_state = glan_pkg::GLAN_COMPLETE_ACK;
                  next_timer = '0;
               end else if (rx_config_valid_i && rx_config_word_i == 16'h0000) begin
                  next_state = glan_pkg::GLAN_RESTART;
                  next_timer = '0;
               end
            end
            glan_pkg::GLAN_COMPLETE_ACK: begin
               next_tx_word = (extra_phase ? extra_word : base_page);
               next_tx_word[`GLAN_BIT_ACK] = 1'b1;
               next_timer = timer + CW'(1);
               if (timer_done) begin
                  next_timer = '0;
                  clr_match  = 1'b1;
                  next_pword = match_word;
                  if (!extra_phase) begin
                     next_pfault = (match_word[`GLAN_BIT_RF_HI:`GLAN_BIT_RF_LO] != 2'h0);
                  end else begin
                     next_nprx = 1'b1;
                  end
                  // Further pages if either end still asks for them
                  if (match_word[`GLAN_BIT_MORE] ||
                      (extra_phase ? extra_word[`GLAN_BIT_MORE] : more_pages_request_i)) begin
                     next_state       = glan_pkg::GLAN_NEXT_PAGE_WAIT;
                     next_extra_phase = 1'b1;
                  end else begin
                     next_state = glan_pkg::GLAN_LINK_OK;
                  end
               end
            end
            glan_pkg::GLAN_NEXT_PAGE_WAIT: begin
               // Ack held until software loads the next outgoing page
               next_tx_word = extra_word;
               next_tx_word[`GLAN_BIT_ACK] = 1'b1;
               if (next_page_load_i) begin
                  next_state = glan_pkg::GLAN_ABILITY;
               end
            end
            glan_pkg::GLAN_LINK_OK: begin
               // Negotiated mode applied only here, after both acks and all pages; forced mode is set in the an_enable_i low branch
               next_tx_en    = 1'b0;
               next_complete = 1'b1;
               next_full     = common_full;
               next_err      = !(common_full || common_half);
               next_link     = rx_idle_i && (common_full || common_half);
               if (match_word[`GLAN_BIT_PAUSE] && symmetric_pause_ability_i) begin
                  next_pause = glan_pkg::GLAN_PAUSE_SYM;
               end else if (asymmetric_pause_direction_i && match_word[`GLAN_BIT_ASYM] &&
                            symmetric_pause_ability_i && !match_word[`GLAN_BIT_PAUSE]) begin
                  next_pause = glan_pkg::GLAN_PAUSE_ASYM_RX;
               end else if (asymmetric_pause_direction_i && match_word[`GLAN_BIT_ASYM] &&
                            !symmetric_pause_ability_i && match_word[`GLAN_BIT_PAUSE]) begin
                  next_pause = glan_pkg::GLAN_PAUSE_ASYM_TX;
               end else begin
                  next_pause = glan_pkg::GLAN_PAUSE_NONE;
               end
               if (rx_config_valid_i) begin
                  // Partner restarted: follow it
                  next_state    = glan_pkg::GLAN_RESTART;
                  next_timer    = '0;
                  next_complete = 1'b0;
                  next_link     = 1'b0;
                  next_extra_phase = 1'b0;
               end
            end
            default: begin
               next_state = glan_pkg::GLAN_RESTART;
               next_timer = '0;
            end
         endcase
      end
      // Words leave on the link only; nothing goes to the data interface
      next_tx_word = next_tx_word & ~`GLAN_RSVD_MASK;
   end

   // Registers only; status outputs laid out as management bits
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         state              <= glan_pkg::GLAN_RESTART;
         timer              <= '0;
         extra_phase        <= 1'b0;
         extra_word         <= 16'h0000;
         tx_config_en_o     <= 1'b1;
         tx_config_word_o   <= 16'h0000;
         an_complete_o      <= 1'b0;
         link_up_o          <= 1'b0;
         mode_full_duplex_o <= 1'b0;
         mode_pause_o       <= 2'h0;
         partner_fault_o    <= 1'b0;
         an_error_o         <= 1'b0;
         partner_word_o     <= 16'h0000;
         next_page_rx_o     <= 1'b0;
      end else begin
         state              <= next_state;
         timer              <= next_timer;
         extra_phase        <= next_extra_phase;
         extra_word         <= next_extra_word;
         tx_config_en_o     <= next_tx_en;
         tx_config_word_o   <= next_tx_word;
         an_complete_o      <= next_complete;
         link_up_o          <= next_link;
         mode_full_duplex_o <= next_full;
         mode_pause_o       <= next_pause;
         partner_fault_o    <= next_pfault;
         an_error_o         <= next_err;
         partner_word_o     <= next_pword;
         next_page_rx_o     <= next_nprx;
      end
   end
endmodule

// *** sim/glan_autoneg_monitor.sv ***
// Checker for the link negotiation block, bound to its ports
`timescale 1ns/1ps
module glan_autoneg_monitor #(
   parameter int LINK_CYCLES = 8
) (
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire logic        an_enable_i,
   input wire logic        an_restart_i,
   input wire logic        phy_error_i,
   input wire logic        force_full_duplex_i,
   input wire logic        rx_config_valid_i,
   input wire logic [15:0] rx_config_word_i,
   input wire logic        tx_config_en_o,
   input wire logic [15:0] tx_config_word_o,
   input wire logic        an_complete_o,
   input wire logic        link_up_o,
   input wire logic        mode_full_duplex_o,
   input wire logic [1:0]  mode_pause_o
);
   logic [15:0] last_rx;
   int          match_cnt;
   int          ack_run;
   logic        p_ack;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   // Count equal partner words (Ack ignored) and cycles spent sending Ack
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         last_rx <= 16'h0000;
         match_cnt <= 0;
         ack_run <= 0;
         p_ack <= 1'b0;
      end else begin
         ack_run <= (tx_config_en_o && tx_config_word_o[14]) ? ack_run + 1 : 0;
         if (tx_config_en_o && tx_config_word_o == 16'h0000) p_ack <= 1'b0;
         if (rx_config_valid_i) begin
            last_rx <= rx_config_word_i;
            match_cnt <= (((rx_config_word_i ^ last_rx) & 16'hBFFF) == 16'h0000) ?
                         match_cnt + 1 : 1;
            if (rx_config_word_i[14]) p_ack <= 1'b1;
         end
      end
   end
   a_rsvd_zero: assert property (
      tx_config_en_o |-> (tx_config_word_o & 16'h0E1F) == 16'h0000) else $error("reserved bit sent");
   a_reset_zeros: assert property (
      $rose(reset_n_i) |-> (tx_config_en_o && tx_config_word_o == 16'h0000)[*8])
      else $error("no zero words after reset");
   a_restart_cfg: assert property (
      an_enable_i && (an_restart_i || phy_error_i) |=> tx_config_en_o && tx_config_word_o == 16'h0000)
      else $error("restart did not send zero words");
   a_ack_match: assert property (
      $rose(tx_config_word_o[14]) && tx_config_en_o |-> match_cnt >= 3) else $error("early ack");
   a_ack_hold: assert property (
      $fell(tx_config_en_o) && an_enable_i |-> ack_run >= LINK_CYCLES + 1) else $error("ack too short");
   a_complete_quiet: assert property (
      $rose(an_complete_o) && an_enable_i |-> !tx_config_en_o &&
      $past(tx_config_en_o && tx_config_word_o[14]))
      else $error("complete while sending");
   a_complete_ack: assert property (
      $rose(an_complete_o) && an_enable_i |-> p_ack) else $error("complete without partner ack");
   a_forced_mode: assert property (
      !an_enable_i [*4] |-> !tx_config_en_o && link_up_o && mode_pause_o == 2'h0
      && mode_full_duplex_o == force_full_duplex_i) else $error("forced mode wrong");
   // Main scenarios reached
   cover property ($rose(an_complete_o));
   cover property ($rose(tx_config_word_o[14]));
   cover property (!an_enable_i ##1 link_up_o);
endmodule

// *** sim/glan_partner.sv ***
// Link partner model: repeats its page in config words
`timescale 1ns/1ps
module glan_partner (
   input  wire logic        clk_sys_i,
   input  wire logic        send_i,
   input  wire logic        slow_i,
   input  wire logic        full_dup_i,
   input  wire logic [1:0]  ps_i,
   input  wire logic        ack_i,
   output logic             valid_o,
   output logic [15:0]      word_o,
   output logic             idle_o
);
   logic [2:0]  tick = 3'h0;
   logic [15:0] last = 16'h0000;
   logic [15:0] page;
   // Half duplex always offered, fault none, no next pages
   assign page = {1'b0, ack_i, 2'h0, 3'h0, ps_i[1], ps_i[0], 1'b1, full_dup_i, 5'h00};
   // A word every 2nd or 5th cycle; between words the line shows a stale inverse
   always_ff @(posedge clk_sys_i) begin
      tick <= (tick >= (slow_i ? 3'h4 : 3'h1)) ? 3'h0 : tick + 3'h1;
      if (valid_o) last <= page;
   end
   assign valid_o = send_i && tick == 3'h0;
   assign word_o  = valid_o ? page : ~last;
   assign idle_o  = !send_i;
endmodule

// *** sim/glan_autoneg_test.sv ***
// Self-checking bench for the link negotiation block
`timescale 1ns/1ps
module glan_autoneg_test;
   logic        clk_sys_i, reset_n_i, an_enable_i, an_restart_i, force_full_duplex_i;
   logic        full_duplex_ability_i, half_duplex_ability_i, symmetric_pause_ability_i;
   logic        asymmetric_pause_direction_i, more_pages_request_i, next_page_load_i;
   logic        phy_error_i, rx_config_valid_i, rx_idle_i, tx_config_en_o, an_complete_o;
   logic        link_up_o, mode_full_duplex_o, partner_fault_o, an_error_o, next_page_rx_o;
   logic [1:0]  fault_code_i, mode_pause_o, p_ps;
   logic [15:0] next_page_word_i, rx_config_word_i, tx_config_word_o, partner_word_o;
   logic        base_up, ack_up, p_send, p_slow, p_full, p_ack;
   int          num_errors, n_tests;
   assign base_up = tx_config_word_o[5];
   assign ack_up = tx_config_word_o[14];
   glan_autoneg #(.LINK_CYCLES(8)) i_dut (.clk_sys_i, .reset_n_i, .an_enable_i, .an_restart_i,
      .force_full_duplex_i, .full_duplex_ability_i, .half_duplex_ability_i,
      .symmetric_pause_ability_i, .asymmetric_pause_direction_i, .fault_code_i,
      .more_pages_request_i, .next_page_word_i, .next_page_load_i, .phy_error_i,
      .rx_config_valid_i, .rx_config_word_i, .rx_idle_i, .tx_config_en_o, .tx_config_word_o,
      .an_complete_o, .link_up_o, .mode_full_duplex_o, .mode_pause_o, .partner_fault_o,
      .an_error_o, .partner_word_o, .next_page_rx_o);
   glan_partner i_partner (.clk_sys_i, .send_i(p_send), .slow_i(p_slow), .full_dup_i(p_full),
      .ps_i(p_ps), .ack_i(p_ack), .valid_o(rx_config_valid_i), .word_o(rx_config_word_i),
      .idle_o(rx_idle_i));
   // 50 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic step();
      @(posedge clk_sys_i);
      #1;
   endtask
   // Bounded wait, so a stuck handshake shows up as one mismatch
   task automatic wait_sig(ref logic s, input logic v, input string msg);
      int k;
      k = 0;
      while (s !== v && k < 400) begin
         step();
         k++;
      end
      check({15'h0000, s}, {15'h0000, v}, msg);
   endtask
   function automatic int pause_res(int l1, int l2, int p1, int p2);
      if (l1 && p1) return 2;
      if (!l1 && l2 && p1 && p2) return 1;
      if (l1 && l2 && !p1 && p2) return 3;
      return 0;
   endfunction
   // One negotiation (kind 1: base page only), then restart by command, error or a word in link-ok
   task automatic round(input int kind);
      int exp;
      logic both_ok;
      half_duplex_ability_i = 1'($urandom);
      symmetric_pause_ability_i = 1'($urandom);
      asymmetric_pause_direction_i = 1'($urandom);
      fault_code_i = 2'($urandom);
      more_pages_request_i = (kind == 1);
      p_full = 1'($urandom);
      p_ps = 2'($urandom);
      p_slow = 1'($urandom);
      exp = 32 + 64 * half_duplex_ability_i + 128 * symmetric_pause_ability_i
         + 256 * asymmetric_pause_direction_i + 4096 * fault_code_i + 32768 * (kind == 1);
      wait_sig(base_up, 1'b1, "base page");
      check(tx_config_word_o, 16'(exp), "base word");
      if (kind != 1) begin
         p_send = 1'b1;
         wait_sig(ack_up, 1'b1, "ack");
         check(tx_config_word_o, 16'(exp + 16384), "ack word");
         p_ack = 1'b1;
         // Go quiet while the acked page is timed out; any word in link-ok restarts
         repeat (6) step();
         p_send = 1'b0;
         wait_sig(an_complete_o, 1'b1, "complete");
         both_ok = p_full | half_duplex_ability_i;
         check({15'h0000, tx_config_en_o}, 16'h0000, "config stop");
         check({15'h0000, link_up_o}, {15'h0000, both_ok}, "link");
         check({15'h0000, an_error_o}, {15'h0000, !both_ok}, "no common");
         check({15'h0000, partner_fault_o}, 16'h0000, "partner fault");
         check(partner_word_o, 16'(16384 + 32 * p_full + 64 + 128 * p_ps[0] + 256 * p_ps[1]),
            "rx");
         check({15'h0000, mode_full_duplex_o}, {15'h0000, p_full}, "duplex");
         check({14'h0000, mode_pause_o}, 16'(pause_res(symmetric_pause_ability_i,
            asymmetric_pause_direction_i, p_ps[0], p_ps[1])), "pause");
         p_ack = 1'b0;
      end
      an_restart_i = (kind < 2);
      phy_error_i = (kind == 2);
      p_send = (kind == 3);
      step();
      an_restart_i = 1'b0;
      phy_error_i = 1'b0;
      wait_sig(tx_config_en_o, 1'b1, "restart");
      p_send = 1'b0;
      check(tx_config_word_o, 16'h0000, "restart word");
   endtask
   task automatic stop_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(29));
      {reset_n_i, an_restart_i, phy_error_i, more_pages_request_i, next_page_load_i} = 5'h00;
      {force_full_duplex_i, p_send, p_slow, p_full, p_ack, p_ps} = 7'h00;
      {half_duplex_ability_i, symmetric_pause_ability_i, asymmetric_pause_direction_i} = 3'h0;
      an_enable_i = 1'b1;
      full_duplex_ability_i = 1'b1;
      fault_code_i = 2'h0;
      next_page_word_i = 16'h0000;
      repeat (6) @(posedge clk_sys_i);
      #1 reset_n_i = 1'b1;
      check({tx_config_en_o, tx_config_word_o[14:0]}, 16'h8000, "reset");
      for (int r = 0; r < 8; r++) round(r % 4);
      force_full_duplex_i = 1'($urandom);
      an_enable_i = 1'b0;
      repeat (5) step();
      check({tx_config_en_o, link_up_o}, 16'h0001, "forced");
      check({15'h0000, mode_full_duplex_o}, {15'h0000, force_full_duplex_i}, "fdx");
      an_enable_i = 1'b1;
      wait_sig(tx_config_en_o, 1'b1, "enable");
      round(0);
      stop_test();
   end
   // Watchdog well beyond nine rounds
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      num_errors++;
      stop_test();
   end
endmodule
bind glan_autoneg glan_autoneg_monitor #(.LINK_CYCLES(LINK_CYCLES)) i_mon (.clk_sys_i,
   .reset_n_i, .an_enable_i, .an_restart_i, .phy_error_i, .force_full_duplex_i,
   .rx_config_valid_i, .rx_config_word_i, .tx_config_en_o, .tx_config_word_o, .an_complete_o,
   .link_up_o, .mode_full_duplex_o, .mode_pause_o);
